// ---- rtl/power_mode_params.svh ----
// Constants of the ranging power and mode controller: command codes,
// register locations, limits and timing figures.
// Assumes a 200 MHz reference clock and an upstream frame/I2C decoder.
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define NS_PER_US 1000
`define AWAKE_TIME_US 8500
`define MS_TIME_US 1000
`define MS_PER_S 11'h3E8

// ==========================================================
// Serial command identifiers
`define CMD_OUT_FREQ 8'h03
`define CMD_SINGLE_MEASURE 8'h04
`define CMD_AUTO_LOW_DUTY 8'h35
`define CMD_DEEP_SLEEP 8'h58
`define CMD_PERSIST 8'h11
`define CMD_RESTART 8'h02
`define CMD_FREQ_MODE 8'h3F

// ==========================================================
// I2C register locations and values
`define ULP_CTRL_ADDR 8'h1F
`define ULP_SAVE_ADDR 8'h20
`define ULP_RESET_ADDR 8'h21
`define ULP_ON 8'h01
`define ULP_OFF 8'h00
`define ULP_SAVE_VAL 8'h01
`define ULP_RESET_VAL 8'h02
`define I2C_SLAVE_ADDR 7'h10

// ==========================================================
// Limits
`define AUTO_MAX_HZ 4'hA
`define SINGLE_RANGE_CM 16'h05DC
`define DUAL_RANGE_CM 16'h1964
`define AMP_HIGH 16'h7530
`define AMP_LOW 16'h0064

`endif

// ---- rtl/power_mode_pkg.sv ----
// Types shared by the power and mode controller.
// Assumes the params header supplies all numeric constants.
package power_mode_pkg;

  typedef enum logic [1:0] {MODE_CONT, MODE_TRIG, MODE_AUTO, MODE_SLEEP} mode_t;
  typedef enum logic [1:0] {WK_IDLE, WK_MEASURE, WK_REPLY, WK_HOLD} wake_t;

  // Decoded serial command, one-cycle valid
  typedef struct packed {
    logic valid;
    logic [7:0] id;
    logic [7:0] arg;
  } cmd_t;

  // Decoded I2C register write byte, one-cycle valid
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage : power_mode_pkg

// ---- rtl/emitter_gear_select.sv ----
// Adaptive emitter current gear.
// Assumes amp_valid_i pulses once per finished measurement.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module emitter_gear_select #(
  parameter int unsigned GEAR_W = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Measurement result
  input wire logic amp_valid_i,
  input wire logic [15:0] amp_i,
  // Gear
  output logic [GEAR_W-1:0] gear_o
);
  // Start high so the first shot is not lost to a weak return
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gear_o <= '1;
    end else if (ce_i && amp_valid_i) begin
      if (amp_i > `AMP_HIGH && gear_o != '0) begin
        gear_o <= gear_o - 1'b1;
      end else if (amp_i < `AMP_LOW && gear_o != '1) begin
        gear_o <= gear_o + 1'b1;
      end
    end
  end
endmodule : emitter_gear_select

// ---- rtl/low_duty_timer.sv ----
// Internal trigger timer for the automatic low-duty mode.
// Assumes rate_hz_i is already capped by the caller.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module low_duty_timer #(
  parameter int unsigned MS_CYCLES = (`MS_TIME_US * `NS_PER_US) / `CLK_PERIOD_NS,
  parameter int unsigned RATE_W = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control
  input wire logic enable_i,
  input wire logic [RATE_W-1:0] rate_hz_i,
  // Trigger pulse
  output logic tick_o
);
  localparam int unsigned PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);
  logic [PRE_W-1:0] pre_reg;
  logic [10:0] acc_reg;
  logic [10:0] acc_next;

  // Phase accumulator avoids a divider: rate added each ms, tick on wrap
  assign acc_next = acc_reg + 11'(rate_hz_i);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pre_reg <= '0;
    end else if (ce_i) begin
      pre_reg <= (!enable_i || pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!enable_i) begin
        acc_reg <= '0;
      end else if (pre_reg == PRE_LAST) begin
        if (acc_next >= `MS_PER_S) begin
          acc_reg <= acc_next - `MS_PER_S;
          tick_o <= 1'b1;
        end else begin
          acc_reg <= acc_next;
        end
      end
    end
  end
endmodule : low_duty_timer

// ---- rtl/ranging_power_mode_control.sv ----
// Power and operating-mode controller of the ranging sensor.
// Assumes a frame decoder delivering serial commands, an I2C slave
// delivering register writes and read completions, and a ranging core.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module ranging_power_mode_control
  import power_mode_pkg::*;
#(
  parameter int unsigned AWAKE_CYCLES = (`AWAKE_TIME_US * `NS_PER_US) / `CLK_PERIOD_NS,
  parameter int unsigned MS_CYCLES = (`MS_TIME_US * `NS_PER_US) / `CLK_PERIOD_NS,
  parameter int unsigned GEAR_W = 2,
  parameter int unsigned CNT_W = 21
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Straps and stored settings, read once after reset
  input wire logic i2c_strap_i,
  input wire logic saved_ulp_i,
  // Serial side
  input wire cmd_t cmd_i,
  input wire logic rx_activity_i,
  input wire logic frame_sent_i,
  // I2C side
  input wire reg_wr_t i2c_wr_i,
  input wire logic i2c_read_done_i,
  input wire logic sda_activity_i,
  // Ranging core
  input wire logic measure_done_i,
  input wire logic [15:0] amp_i,
  // Mode and power control
  output mode_t mode_o,
  output logic emitter_en_o,
  output logic measure_start_o,
  output logic [GEAR_W-1:0] gear_o,
  output logic dual_freq_o,
  output logic [15:0] range_limit_cm_o,
  // Host-facing status
  output logic serial_tx_en_o,
  output logic rx_en_o,
  output logic frame_req_o,
  output logic cmd_ack_o,
  output logic persist_ulp_o,
  output logic [6:0] i2c_addr_o
);
  localparam logic [CNT_W-1:0] AWAKE_LAST = CNT_W'(AWAKE_CYCLES - 1);

  // ==========================================================
  // State
  mode_t mode_reg;
  wake_t wake_reg;
  logic boot_reg;
  logic i2c_mode_reg;
  logic ulp_req_reg;
  logic saved_reg;
  logic busy_reg;
  logic seq_ctrl_reg;
  logic seq_save_reg;
  logic ulp_val_reg;
  logic [3:0] rate_reg;
  logic [CNT_W-1:0] awake_cnt_reg;
  logic auto_tick;
  logic cmd_take;
  logic i2c_take;
  logic wake_ev;
  logic trig_ev;
  logic start_now;
  logic seq_apply;

  assign mode_o = mode_reg;
  assign persist_ulp_o = saved_reg;

  // ==========================================================
  // Request qualification
  // rx_en_o is low while asleep between wake windows, so nothing is taken then
  assign cmd_take = ce_i && cmd_i.valid && rx_en_o && !i2c_mode_reg;
  assign i2c_take = ce_i && i2c_wr_i.valid && rx_en_o && i2c_mode_reg;
  // A wake heard while an older shot still runs is dropped, so each wake owns its shot
  assign wake_ev = ce_i && mode_reg == MODE_SLEEP && wake_reg == WK_IDLE && !busy_reg
                   && (i2c_mode_reg ? sda_activity_i : rx_activity_i);
  assign trig_ev = cmd_take && cmd_i.id == `CMD_SINGLE_MEASURE && mode_reg == MODE_TRIG;
  assign seq_apply = i2c_take && seq_save_reg && i2c_wr_i.addr == `ULP_RESET_ADDR
                     && i2c_wr_i.data == `ULP_RESET_VAL;
  // Nothing launches in the boot cycle: the stored mode is not known yet
  assign start_now = !busy_reg && !boot_reg && (wake_ev || trig_ev
                     || (ce_i && mode_reg == MODE_AUTO && auto_tick)
                     || (ce_i && mode_reg == MODE_CONT));

  // ==========================================================
  // Boot capture of straps
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      boot_reg <= 1'b1;
      i2c_mode_reg <= 1'b0;
      i2c_addr_o <= `I2C_SLAVE_ADDR;
    end else if (ce_i && boot_reg) begin
      boot_reg <= 1'b0;
      i2c_mode_reg <= i2c_strap_i;
    end
  end

  // ==========================================================
  // Operating mode, a single enum so only one can hold
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_reg <= MODE_CONT;
    end else if (ce_i) begin
      if (boot_reg) begin
        mode_reg <= saved_ulp_i ? MODE_SLEEP : MODE_CONT;
      end else if (seq_apply) begin
        mode_reg <= ulp_val_reg ? MODE_SLEEP : MODE_CONT;
      end else if (cmd_take) begin
        case (cmd_i.id)
          `CMD_OUT_FREQ: begin
            if (mode_reg != MODE_SLEEP) begin
              mode_reg <= (cmd_i.arg == '0) ? MODE_TRIG : MODE_CONT;
            end
          end
          `CMD_AUTO_LOW_DUTY: begin
            if (mode_reg != MODE_SLEEP) begin
              mode_reg <= (cmd_i.arg == '0) ? MODE_CONT : MODE_AUTO;
            end
          end
          `CMD_DEEP_SLEEP: begin
            // Heard during a wake window: the host is asking to leave
            if (mode_reg == MODE_SLEEP) begin
              mode_reg <= MODE_CONT;
            end
          end
          `CMD_RESTART: begin
            if (saved_reg && ulp_req_reg) begin
              mode_reg <= MODE_SLEEP;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Deep sleep request and its stored copy
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ulp_req_reg <= 1'b0;
      saved_reg <= 1'b0;
    end else if (ce_i) begin
      if (boot_reg) begin
        ulp_req_reg <= saved_ulp_i;
        saved_reg <= saved_ulp_i;
      end else if (seq_apply) begin
        ulp_req_reg <= ulp_val_reg;
        saved_reg <= ulp_val_reg;
      end else if (cmd_take && cmd_i.id == `CMD_DEEP_SLEEP) begin
        ulp_req_reg <= (mode_reg != MODE_SLEEP);
      end else if (cmd_take && cmd_i.id == `CMD_PERSIST) begin
        saved_reg <= ulp_req_reg;
      end
    end
  end

  // ==========================================================
  // I2C enable/disable byte sequence tracking
  // Any out-of-order write drops the sequence; it must restart at 0x1F
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      seq_ctrl_reg <= 1'b0;
      seq_save_reg <= 1'b0;
      ulp_val_reg <= 1'b0;
    end else if (i2c_take) begin
      seq_ctrl_reg <= i2c_wr_i.addr == `ULP_CTRL_ADDR
                      && (i2c_wr_i.data == `ULP_ON || i2c_wr_i.data == `ULP_OFF);
      seq_save_reg <= seq_ctrl_reg && i2c_wr_i.addr == `ULP_SAVE_ADDR
                      && i2c_wr_i.data == `ULP_SAVE_VAL;
      if (i2c_wr_i.addr == `ULP_CTRL_ADDR) begin
        ulp_val_reg <= i2c_wr_i.data == `ULP_ON;
      end
    end
  end

  // ==========================================================
  // Automatic low-duty rate, capped
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rate_reg <= `AUTO_MAX_HZ;
    end else if (cmd_take && cmd_i.id == `CMD_AUTO_LOW_DUTY && cmd_i.arg != '0) begin
      rate_reg <= (cmd_i.arg > {4'h0, `AUTO_MAX_HZ}) ? `AUTO_MAX_HZ : cmd_i.arg[3:0];
    end
  end

  low_duty_timer #(
    .MS_CYCLES(MS_CYCLES),
    .RATE_W(4)
  ) u_timer (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(mode_reg == MODE_AUTO),
    .rate_hz_i(rate_reg),
    .tick_o(auto_tick)
  );

  emitter_gear_select #(
    .GEAR_W(GEAR_W)
  ) u_gear (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .amp_valid_i(measure_done_i),
    .amp_i(amp_i),
    .gear_o(gear_o)
  );

  // ==========================================================
  // Modulation frequency selection
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      dual_freq_o <= 1'b1;
      range_limit_cm_o <= `DUAL_RANGE_CM;
    end else if (cmd_take && cmd_i.id == `CMD_FREQ_MODE && mode_reg != MODE_SLEEP) begin
      dual_freq_o <= !cmd_i.arg[0];
      range_limit_cm_o <= cmd_i.arg[0] ? `SINGLE_RANGE_CM : `DUAL_RANGE_CM;
    end
  end

  // ==========================================================
  // Measurement launch and emitter drive
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      measure_start_o <= 1'b0;
      emitter_en_o <= 1'b0;
    end else if (ce_i) begin
      measure_start_o <= start_now;
      busy_reg <= start_now || (busy_reg && !measure_done_i);
      // Full duty in continuous mode whatever the output rate
      emitter_en_o <= mode_reg == MODE_CONT || start_now
                      || (busy_reg && !measure_done_i);
    end
  end

  // ==========================================================
  // Wake-up sequencing while in deep sleep
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wake_reg <= WK_IDLE;
    end else if (ce_i) begin
      if (mode_reg != MODE_SLEEP) begin
        wake_reg <= WK_IDLE;
      end else begin
        case (wake_reg)
          WK_IDLE: begin
            if (wake_ev) begin
              wake_reg <= WK_MEASURE;
            end
          end
          WK_MEASURE: begin
            if (measure_done_i) begin
              wake_reg <= i2c_mode_reg ? WK_HOLD : WK_REPLY;
            end
          end
          WK_REPLY: begin
            if (frame_sent_i) begin
              wake_reg <= WK_HOLD;
            end
          end
          WK_HOLD: begin
            if (i2c_mode_reg ? i2c_read_done_i : awake_cnt_reg >= AWAKE_LAST) begin
              wake_reg <= WK_IDLE;
            end
          end
          default: begin
            wake_reg <= WK_IDLE;
          end
        endcase
      end
    end
  end

  // Awake window measured from the wake event
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      awake_cnt_reg <= '0;
    end else if (ce_i) begin
      if (wake_reg == WK_IDLE) begin
        awake_cnt_reg <= '0;
      end else if (awake_cnt_reg != '1) begin
        awake_cnt_reg <= awake_cnt_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial output and receiver gating
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      serial_tx_en_o <= 1'b0;
      rx_en_o <= 1'b0;
      frame_req_o <= 1'b0;
      cmd_ack_o <= 1'b0;
    end else if (ce_i) begin
      if (boot_reg) begin
        serial_tx_en_o <= 1'b0;
        rx_en_o <= 1'b0;
      end else if (cmd_take && cmd_i.id == `CMD_DEEP_SLEEP && mode_reg != MODE_SLEEP) begin
        serial_tx_en_o <= 1'b0;
        rx_en_o <= 1'b1;
      end else begin
        serial_tx_en_o <= !i2c_mode_reg && (!ulp_req_reg || wake_reg != WK_IDLE);
        rx_en_o <= !(mode_reg == MODE_SLEEP && wake_reg == WK_IDLE)
                   && !(mode_reg == MODE_SLEEP && wake_reg == WK_HOLD && i2c_mode_reg
                        && i2c_read_done_i);
      end
      frame_req_o <= measure_done_i && serial_tx_en_o;
      cmd_ack_o <= cmd_take;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence serial_wake_s;
    wake_ev && !i2c_mode_reg;
  endsequence

  sequence restart_armed_s;
    cmd_take && cmd_i.id == `CMD_RESTART && saved_reg && ulp_req_reg && !boot_reg;
  endsequence

  trig_launch_a: assert property (trig_ev && !busy_reg |=> measure_start_o)
    else $error("trigger command did not launch a measurement");
  cont_emit_a: assert property (ce_i && mode_reg == MODE_CONT |=> emitter_en_o)
    else $error("emitter off in continuous mode");
  tx_stop_a: assert property (cmd_take && cmd_i.id == `CMD_DEEP_SLEEP && mode_reg != MODE_SLEEP
                              |=> !serial_tx_en_o ##1 (!serial_tx_en_o || !ce_i || wake_reg != WK_IDLE))
    else $error("serial output kept running after deep sleep command");
  rx_sleep_a: assert property (ce_i && mode_reg == MODE_SLEEP && wake_reg == WK_IDLE && !boot_reg
                               |=> !rx_en_o)
    else $error("receiver enabled while asleep");
  restart_sleep_a: assert property (restart_armed_s |=> mode_reg == MODE_SLEEP)
    else $error("restart did not enter deep sleep");
  wake_measure_a: assert property (serial_wake_s |=> measure_start_o && wake_reg == WK_MEASURE)
    else $error("serial wake did not start one measurement");
  rate_cap_a: assert property (cmd_take && cmd_i.id == `CMD_AUTO_LOW_DUTY && cmd_i.arg > {4'h0, `AUTO_MAX_HZ}
                               |=> rate_reg == `AUTO_MAX_HZ)
    else $error("auto low-duty rate not capped");
  i2c_enter_a: assert property (seq_apply && ulp_val_reg && !boot_reg |=> mode_reg == MODE_SLEEP)
    else $error("I2C sequence did not enter deep sleep");
  i2c_hold_a: assert property (ce_i && mode_reg == MODE_SLEEP && wake_reg == WK_HOLD && i2c_mode_reg
                               && !i2c_read_done_i && !seq_apply |=> wake_reg == WK_HOLD)
    else $error("I2C wake ended before a register read");
  boot_sleep_a: assert property (ce_i && boot_reg && saved_ulp_i |=> mode_reg == MODE_SLEEP)
    else $error("saved deep sleep not entered at start-up");

endmodule : ranging_power_mode_control

// ---- bench/range_host_model.sv ----
// Far-side model: ranging core answering start pulses and the host's serial
// transmitter finishing each requested result frame.
// Assumes the controller issues one-cycle start and frame request pulses.
`timescale 1ns/1ps
module range_host_model #(
  parameter int unsigned MEAS_LAT = 8,
  parameter int unsigned FRAME_LAT = 10
) (
  // Clock
  input wire logic ref_clk_i,
  // From the controller
  input wire logic start_i,
  input wire logic frame_req_i,
  input wire logic [15:0] amp_val_i,
  // To the controller
  output logic done_o,
  output logic [15:0] amp_o,
  output logic sent_o
);
  int m_cnt = 0;
  int f_cnt = 0;
  initial begin
    done_o = 1'b0;
    sent_o = 1'b0;
    amp_o = 16'hFFFF;
  end
  // ==========================================================
  // Strength is only meaningful with done; otherwise show a changing value
  always @(posedge ref_clk_i) begin
    done_o <= (m_cnt == 1);
    amp_o <= (m_cnt == 1) ? amp_val_i : ~amp_o;
    sent_o <= (f_cnt == 1);
    if (start_i) m_cnt <= MEAS_LAT;
    else if (m_cnt > 0) m_cnt <= m_cnt - 1;
    if (frame_req_i) f_cnt <= FRAME_LAT;
    else if (f_cnt > 0) f_cnt <= f_cnt - 1;
  end
endmodule : range_host_model

// ---- bench/ranging_power_mode_control_bench.sv ----
// Self-checking bench of the power and mode controller.
// Assumes shortened awake and millisecond counts for simulation.
`timescale 1ns/1ps
module ranging_power_mode_control_bench;
  import power_mode_pkg::*;
  localparam int AWAKE = 50;
  localparam int MSC = 20;
  logic clk, rst_n, ce, strap, saved, rx_act, sda_act, rd_done, m_done, f_sent;
  cmd_t cmd;
  reg_wr_t wr;
  logic [15:0] amp, amp_val;
  mode_t mode;
  logic emit, start, dual, tx_en, rx_en, f_req, ack, persist;
  logic [1:0] gear;
  logic [15:0] rlim;
  logic [6:0] addr;
  int errors = 0;
  int n_checks = 0;
  int starts = 0;
  int frames = 0;
  int acks = 0;
  int n, s0, f0, a0;
  ranging_power_mode_control #(.AWAKE_CYCLES(AWAKE), .MS_CYCLES(MSC)) dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .i2c_strap_i(strap), .saved_ulp_i(saved),
    .cmd_i(cmd), .rx_activity_i(rx_act), .frame_sent_i(f_sent), .i2c_wr_i(wr),
    .i2c_read_done_i(rd_done), .sda_activity_i(sda_act), .measure_done_i(m_done), .amp_i(amp),
    .mode_o(mode), .emitter_en_o(emit), .measure_start_o(start), .gear_o(gear), .dual_freq_o(dual),
    .range_limit_cm_o(rlim), .serial_tx_en_o(tx_en), .rx_en_o(rx_en), .frame_req_o(f_req),
    .cmd_ack_o(ack), .persist_ulp_o(persist), .i2c_addr_o(addr));
  range_host_model partner (
    .ref_clk_i(clk), .start_i(start), .frame_req_i(f_req), .amp_val_i(amp_val),
    .done_o(m_done), .amp_o(amp), .sent_o(f_sent));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (start === 1'b1) starts++;
    if (f_req === 1'b1) frames++;
    if (ack === 1'b1) acks++;
  end
  // ==========================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task do_reset(input logic st, input logic sv);
    rst_n = 1'b0;
    strap = st;
    saved = sv;
    tick(20);
    rst_n = 1'b1;
    tick(3);
  endtask : do_reset
  task send_cmd(input logic [7:0] id, input logic [7:0] arg);
    @(negedge clk) cmd = {1'b1, id, arg};
    @(negedge clk) cmd = '0;
    tick(2);
  endtask : send_cmd
  task i2c_seq(input logic [7:0] first);
    @(negedge clk) wr = {1'b1, 8'h1F, first};
    @(negedge clk) wr = {1'b1, 8'h20, 8'h01};
    @(negedge clk) wr = {1'b1, 8'h21, 8'h02};
    @(negedge clk) wr = '0;
    tick(3);
  endtask : i2c_seq
  // Lets any shot still in flight finish first: the block drops wakes while busy
  task wake_pulse(input logic on_sda);
    tick(12);
    @(negedge clk) {sda_act, rx_act} = {on_sda, !on_sda};
    @(negedge clk) {sda_act, rx_act} = 2'b00;
  endtask : wake_pulse
  // Bounded waits: for the receiver to open, then counting awake cycles until it closes
  task wait_sleep();
    n = 0;
    while (rx_en !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (rx_en === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_sleep
  task close_out();
    $display("checks=%0d mismatches=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    #300000;
    errors++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial begin
    {rx_act, sda_act, rd_done} = '0;
    ce = 1'b1;
    cmd = '0;
    wr = '0;
    amp_val = 16'h1000;
    do_reset(1'b0, 1'b0);
    check(mode, MODE_CONT);
    check({dual, rlim}, {1'b1, 16'h1964});
    check(addr, 7'h10);
    check(emit, 1'b1);
    $display("test defaults done");
    send_cmd(8'h03, 8'h00);
    tick(20);
    check(mode, MODE_TRIG);
    check(emit, 1'b0);
    amp_val = 16'hFFFF;
    s0 = starts;
    send_cmd(8'h04, 8'h00);
    check(emit, 1'b1);
    tick(20);
    check(starts - s0, 1);
    check(gear, 2'h2);
    amp_val = 16'h0010;
    send_cmd(8'h04, 8'h00);
    tick(20);
    check(gear, 2'h3);
    // A trigger while the clock enable is low must leave no trace
    s0 = starts;
    ce = 1'b0;
    send_cmd(8'h04, 8'h00);
    tick(20);
    ce = 1'b1;
    check(starts - s0, 0);
    $display("test trigger and gear done");
    send_cmd(8'h3F, 8'h01);
    check({dual, rlim}, {1'b0, 16'h05DC});
    send_cmd(8'h3F, 8'h00);
    check({dual, rlim}, {1'b1, 16'h1964});
    $display("test frequency done");
    send_cmd(8'h35, 8'h0F);
    check(mode, MODE_AUTO);
    s0 = starts;
    tick(6000);
    check((starts - s0) inside {2, 3}, 1'b1);
    send_cmd(8'h35, 8'h00);
    check(mode, MODE_CONT);
    send_cmd(8'h02, 8'h00);
    check(mode, MODE_CONT);
    $display("test auto done");
    do_reset(1'b0, 1'b0);
    check(tx_en, 1'b1);
    send_cmd(8'h58, 8'h00);
    check(tx_en, 1'b0);
    send_cmd(8'h11, 8'h00);
    check(mode, MODE_CONT);
    check(persist, 1'b1);
    send_cmd(8'h02, 8'h00);
    check(mode, MODE_SLEEP);
    check(rx_en, 1'b0);
    a0 = acks;
    send_cmd(8'h03, 8'h00);
    check(acks - a0, 0);
    s0 = starts;
    f0 = frames;
    wake_pulse(1'b0);
    wait_sleep();
    check(starts - s0, 1);
    check(frames - f0, 1);
    check(n inside {[AWAKE - 3 : AWAKE + 1]}, 1'b1);
    $display("test serial sleep done");
    do_reset(1'b0, 1'b1);
    check(mode, MODE_SLEEP);
    wake_pulse(1'b0);
    tick(2);
    a0 = acks;
    send_cmd(8'h58, 8'h00);
    check(acks - a0, 1);
    check(mode, MODE_CONT);
    send_cmd(8'h11, 8'h00);
    check(persist, 1'b0);
    $display("test serial exit done");
    do_reset(1'b1, 1'b0);
    a0 = acks;
    send_cmd(8'h03, 8'h00);
    check(acks - a0, 0);
    check(mode, MODE_CONT);
    i2c_seq(8'h01);
    check(mode, MODE_SLEEP);
    check(rx_en, 1'b0);
    s0 = starts;
    wake_pulse(1'b1);
    tick(60);
    check(starts - s0, 1);
    check(rx_en, 1'b1);
    @(negedge clk) rd_done = 1'b1;
    @(negedge clk) rd_done = 1'b0;
    tick(3);
    check(rx_en, 1'b0);
    wake_pulse(1'b1);
    tick(6 * MSC);
    i2c_seq(8'h00);
    check(mode, MODE_CONT);
    $display("test i2c sleep done");
    close_out();
  end
endmodule : ranging_power_mode_control_bench
